// ===== bench/rsbm_checker.sv
// Port checks for the subaddress buffer manager
`timescale 1ns/10ps
`default_nettype none
module rsbm_checker
	import rsbm_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	input wire logic I_MSG_START,
	input wire logic [15:0] I_MSG_CMD,
	input wire logic I_MSG_BCAST,
	input wire logic O_MSG_READY,
	input wire logic I_RX_VALID,
	input wire logic [15:0] I_RX_DATA,
	input wire logic I_TX_REQ,
	input wire logic O_TX_VALID,
	input wire logic [15:0] O_RAM_ADDR,
	input wire logic [15:0] O_RAM_WDATA,
	input wire logic O_RAM_WE,
	input wire logic O_RAM_RE,
	input wire logic [15:0] I_RAM_RDATA,
	input wire logic O_INT_REQ,
	input wire logic [5:0] O_INT_CAUSE
);
	logic area, bsep, bc;
	logic [5:0] mask;
	logic [15:0] cmd, lut, cw_a, ptr_a;
	logic [6:0] sec;
	wire logic wr = I_PSEL && I_PENABLE && I_PWRITE && I_CE;
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	// Shadow settings and the command being served; starts are only sent when idle
	always_ff @(posedge I_MCLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			area <= 1'b0;
			bsep <= 1'b0;
			mask <= IMASK_RESET;
			cmd <= 16'h0000;
			bc <= 1'b0;
		end
		else
		begin
			if (wr && I_PADDR == REG_CFG1)
			begin
				area <= I_PWDATA[CFG_AREA_B];
				bsep <= I_PWDATA[CFG_BC_SEP];
			end
			if (wr && I_PADDR == REG_IMASK)
				mask <= I_PWDATA[5:0];
			if (I_MSG_START && !O_MSG_READY)
			begin
				cmd <= I_MSG_CMD;
				bc <= I_MSG_BCAST;
			end
		end
	end
	// Expected table addresses for the current command
	assign lut = area ? LUT_BASE_B : LUT_BASE_A;
	assign sec = cmd[10] ? SEC_TX : ((bsep && bc) ? SEC_BC : SEC_RX);
	assign cw_a = lut + {9'h000, SEC_CW} + {11'h000, cmd[9:5]};
	assign ptr_a = lut + {9'h000, sec} + {11'h000, cmd[9:5]};
	a_sp_fetch: assert property ($rose(O_MSG_READY) |-> $past(O_RAM_RE, 6) &&
		$past(O_RAM_ADDR, 6) == (area ? STACK_PTR_B : STACK_PTR_A)) else $error("bad sp fetch");
	a_cw_fetch: assert property ($rose(O_MSG_READY) |-> $past(O_RAM_RE, 5) &&
		$past(O_RAM_ADDR, 5) == cw_a) else $error("bad control word fetch");
	a_ptr_fetch: assert property ($rose(O_MSG_READY) |-> $past(O_RAM_RE, 4) &&
		$past(O_RAM_ADDR, 4) == ptr_a) else $error("bad pointer fetch");
	a_desc_ptr: assert property ($rose(O_MSG_READY) |-> $past(O_RAM_WE, 3) &&
		$past(O_RAM_WDATA, 3) == $past(I_RAM_RDATA, 3) &&
		$past(O_RAM_ADDR, 3) == $past(I_RAM_RDATA, 5) + 16'h0002) else $error("bad desc ptr");
	a_desc_cmd: assert property ($rose(O_MSG_READY) |-> $past(O_RAM_WE, 2) &&
		$past(O_RAM_WDATA, 2) == cmd &&
		$past(O_RAM_ADDR, 2) == $past(I_RAM_RDATA, 5) + 16'h0003) else $error("bad desc cmd");
	a_rx_store: assert property (I_RX_VALID && O_MSG_READY && !cmd[10] |->
		O_RAM_WE && O_RAM_WDATA == I_RX_DATA) else $error("rx word not stored");
	a_tx_fetch: assert property (I_TX_REQ && O_MSG_READY |-> ##[2:3] O_TX_VALID)
		else $error("tx word late");
	a_int_masked: assert property (O_INT_REQ |-> (O_INT_CAUSE & ~mask) == 6'h00)
		else $error("masked cause shown");
	c_msg: cover property ($rose(O_MSG_READY));
	c_roll: cover property (O_INT_REQ && O_INT_CAUSE[IRQ_CIRC]);
	c_tx: cover property (I_TX_REQ && O_MSG_READY);
endmodule : rsbm_checker
bind rsbm_top rsbm_checker u_chk (.I_MCLK, .I_RST, .I_CE, .I_PSEL, .I_PENABLE, .I_PWRITE,
	.I_PADDR, .I_PWDATA, .I_MSG_START, .I_MSG_CMD, .I_MSG_BCAST, .O_MSG_READY, .I_RX_VALID,
	.I_RX_DATA, .I_TX_REQ, .O_TX_VALID, .O_RAM_ADDR, .O_RAM_WDATA, .O_RAM_WE, .O_RAM_RE,
	.I_RAM_RDATA, .O_INT_REQ, .O_INT_CAUSE);
`default_nettype wire

// ===== bench/rsbm_ram_model.sv
// Shared RAM partner with a one-cycle synchronous read
`timescale 1ns/10ps
`default_nettype none
module rsbm_ram_model
(
	input wire logic clk,
	input wire logic [15:0] addr,
	input wire logic [15:0] wdata,
	input wire logic we,
	input wire logic re,
	output logic [15:0] rdata
);
	logic [15:0] mem [0:65535];
	logic [15:0] q;
	logic hit;
	// Data stands only in the cycle after a read; the inverse otherwise exposes stale use
	always_ff @(posedge clk)
	begin
		hit <= re;
		if (re)
			q <= mem[addr];
		if (we)
			mem[addr] <= wdata;
	end
	assign rdata = hit ? q : ~q;
endmodule : rsbm_ram_model
`default_nettype wire

// ===== bench/rsbm_top_tb_top.sv
// Self-checking bench for the subaddress buffer manager
`timescale 1ns/10ps
`default_nettype none
module rsbm_top_tb_top;
	import rsbm_pkg::*;
	logic clk = 0, rst = 1, ce = 1, psel = 0, pen = 0, pwr = 0, st = 0, bc = 0;
	logic mend = 0, mok = 0, rxv = 0, txr = 0, ar, err, pready, pslverr, mrdy, txv, we, re, irq;
	logic [7:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd, cfg;
	logic [15:0] cmd = 0, rxd = 0, tt = 0, txd, ra, wd, rdd, lut, sp, ptr;
	logic [15:0] dat [0:31];
	logic [5:0] cause, mk;
	int fails = 0, checked = 0, cyc = 0, seed = 56, r;
	rsbm_top DUT (.I_MCLK(clk), .I_RST(rst), .I_CE(ce), .I_PSEL(psel), .I_PENABLE(pen),
		.I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
		.O_PREADY(pready), .O_PSLVERR(pslverr), .I_MSG_START(st), .I_MSG_CMD(cmd),
		.I_MSG_BCAST(bc), .I_MSG_END(mend), .I_MSG_OK(mok), .O_MSG_READY(mrdy),
		.I_RX_VALID(rxv), .I_RX_DATA(rxd), .I_TX_REQ(txr), .O_TX_VALID(txv), .O_TX_DATA(txd),
		.I_TIME_TAG(tt), .O_RAM_ADDR(ra), .O_RAM_WDATA(wd), .O_RAM_WE(we), .O_RAM_RE(re),
		.I_RAM_RDATA(rdd), .O_INT_REQ(irq), .O_INT_CAUSE(cause));
	rsbm_ram_model ram (.clk(clk), .addr(ra), .wdata(wd), .we(we), .re(re), .rdata(rdd));
	always #50 clk = ~clk;
	// Hang guard, far above the fewer than two thousand cycles the run needs
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 30000)
		begin
			fails++;
			finish_test();
		end
	end
	task automatic check(input string nm, input logic [31:0] got, exp);
		checked++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : check
	task automatic finish_test();
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : finish_test
	function automatic logic [15:0] wrap(input logic [15:0] p, input int i, len);
		return len ? (p & ~16'(len - 1)) | (16'(p + i) & 16'(len - 1)) : 16'(p + i);
	endfunction : wrap
	function automatic logic [15:0] lp(input int off, sa);
		return ram.mem[lut + 16'(off + sa)];
	endfunction : lp
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1;
		do
			@(posedge clk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 0;
		pen <= 0;
		@(posedge clk);
	endtask : apb
	// Host places control word and receive pointer itself
	task automatic put(input int sa, input logic [15:0] cw, p);
		ram.mem[lut + 16'(96 + sa)] = cw;
		ram.mem[lut + 16'(32 + sa)] = p;
	endtask : put
	task automatic msg(input int sa, input logic tr, b, ok, input int n, len,
		input logic [5:0] ec);
		int k = 0;
		sp = ram.mem[ar ? STACK_PTR_B : STACK_PTR_A];
		ptr = lp(tr ? 0 : b ? 64 : 32, sa);
		cmd <= {5'h01, tr, 5'(sa), 5'(n)};
		bc <= b;
		st <= 1;
		@(posedge clk);
		st <= 0;
		do
			@(posedge clk);
		while (mrdy !== 1'b1);
		for (int i = 0; i < n; i++)
		begin
			dat[i] = 16'($random(seed));
			rxv <= !tr;
			txr <= tr;
			rxd <= dat[i];
			@(posedge clk);
			rxv <= 0;
			txr <= 0;
			@(posedge clk);
			// Valid pulse stands one cycle; look mid-cycle while it is settled
			@(negedge clk);
			check("tx valid", txv, tr);
			repeat (2) @(posedge clk);
			if (tr)
				check("tx data", txd, ram.mem[wrap(ptr, i, len)]);
		end
		mend <= 1;
		mok <= ok;
		tt <= 16'($random(seed));
		@(posedge clk);
		mend <= 0;
		// Count request pulses over the whole end sequence
		repeat (10)
		begin
			@(negedge clk);
			k += irq;
		end
		@(posedge clk);
		check("int req", k, 1);
		for (int i = 0; i < n; i++)
			if (!tr)
				check("rx data", ram.mem[wrap(ptr, i, len)], dat[i]);
		check("desc ptr", ram.mem[sp + 16'h0002], ptr);
		check("desc cmd", ram.mem[sp + 16'h0003], cmd);
		check("cause", cause, ec & mk);
	endtask : msg
	// Registers first, then every buffering scheme in both areas
	initial
	begin
		repeat (6) @(posedge clk);
		rst <= 0;
		ram.mem[STACK_PTR_A] = 16'h2000;
		ram.mem[STACK_PTR_B] = 16'h3000;
		for (int i = 0; i < 128; i++)
			ram.mem[16'h0A00 + 16'(i)] = 16'($random(seed));
		apb(0, REG_CFG1, 0);
		check("cfg1", rd, 32'(CFG1_RESET));
		apb(1, 8'h3C, 32'hFFFF_FFFF);
		check("unmapped", err, 1);
		apb(1, REG_STATUS, 1);
		check("status ro", err, 1);
		for (int a = 0; a < 2; a++)
		begin
			ar = a[0];
			lut = a ? LUT_BASE_B : LUT_BASE_A;
			mk = a ? 6'h0D : 6'h3F;
			apb(1, REG_IMASK, 32'(mk));
			apb(0, REG_IMASK, 0);
			check("imask", rd, 32'(mk));
			cfg = 32'(a) << CFG_AREA_B;
			apb(1, REG_CFG1, cfg);
			r = 1 + $unsigned($random(seed)) % 29;
			put(30, 16'h0200, 16'h0800);
			msg(30, 0, 0, 1, 1 + $unsigned($random(seed)) % 32, 0, 6'h05);
			check("single ptr", lp(32, 30), 16'h0800);
			put(r, 16'h8000, 16'h0900);
			msg(r, 0, 0, 1, 1 + $unsigned($random(seed)) % 32, 0, 6'h01);
			check("swap ptr", lp(32, r), 16'h0920);
			ram.mem[lut + 16'(96 + r)] = 16'h0000;
			check("newest", ram.mem[lp(32, r) ^ 16'h0020], dat[0]);
			ram.mem[lut + 16'(96 + r)] = 16'h8000;
			msg(r, 0, 0, 0, 4, 0, 6'h03);
			check("no swap", lp(32, r), 16'h0920);
			for (int c = 1; c < 8; c++)
			begin
				put(r, 16'h0100 | 16'(c << 5), 16'h4000 + 16'(64 << c) - 16'h0002);
				msg(r, 0, 0, 1, 4, 64 << c, 6'h09);
				check("circ ptr", lp(32, r), 16'h4002);
			end
			// Update-after-invalid on, so only the hold option keeps the pointer
			apb(1, REG_CFG1, cfg | 32'h0000_0600);
			msg(r, 0, 0, 0, 4, 8192, 6'h03);
			check("hold ptr", lp(32, r), 16'h4002);
			apb(1, REG_CFG1, cfg | 32'h0000_1800);
			ram.mem[lut + 16'(64 + r)] = 16'h0C00;
			msg(r, 0, 1, 1, 3, 0, 6'h01);
			msg(r, 0, 0, 1, 5, 0, 6'h01);
			check("legacy ptr", lp(32, r), 16'h4002);
			apb(1, REG_CFG1, cfg);
			ram.mem[lut + 16'(96 + r)] = 16'h0400;
			ram.mem[lut + 16'(r)] = 16'h0A7E;
			msg(r, 1, 0, 1, 4, 128, 6'h01);
			check("tx ptr", lp(0, r), 16'h0A02);
			// Mode code 17 on subaddress 0, selected in the mode code table
			apb(1, REG_CFG1, cfg | 32'h0000_0100);
			put(0, 16'h0000, 16'h0B00);
			ram.mem[MC_IRQ_TABLE + 16'h0001] = 16'h0002;
			msg(0, 0, 0, 1, 17, 0, 6'h11);
		end
		finish_test();
	end
endmodule : rsbm_top_tb_top
`default_nettype wire

// ===== pkg/rsbm_pkg.sv
// Constants and types shared by the subaddress buffer manager
package rsbm_pkg;
	localparam logic [15:0] STACK_PTR_A = 16'h0100;
	localparam logic [15:0] STACK_PTR_B = 16'h0104;
	localparam logic [15:0] LUT_BASE_A = 16'h0140;
	localparam logic [15:0] LUT_BASE_B = 16'h01C0;
	localparam logic [15:0] MC_IRQ_TABLE = 16'h0108;
	localparam logic [6:0] SEC_TX = 7'h00_00;
	localparam logic [6:0] SEC_RX = 7'h00_20;
	localparam logic [6:0] SEC_BC = 7'h00_40;
	localparam logic [6:0] SEC_CW = 7'h00_60;
	localparam logic [15:0] CIRC_MIN_LEN = 16'h0080;
	localparam logic [15:0] DBL_TOGGLE = 16'h0020;
	localparam logic [5:0] BLOCK_MAX = 6'h20;
	// APB register byte offsets
	localparam logic [7:0] REG_CFG1 = 8'h00;
	localparam logic [7:0] REG_IMASK = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [15:0] CFG1_RESET = 16'h0000;
	localparam logic [5:0] IMASK_RESET = 6'h00;
	// Configuration register 1 fields
	localparam int CFG_AREA_B = 13;
	localparam int CFG_LEGACY = 12;
	localparam int CFG_BC_SEP = 11;
	localparam int CFG_UPD_INV = 10;
	localparam int CFG_HOLD_RX_INV = 9;
	localparam int CFG_MC_IRQ_EN = 8;
	// Control word: double buffer flag, then tx, rx, bcast fields of five bits
	localparam int CW_DBL = 15;
	localparam int CW_TX_LSB = 10;
	localparam int CW_RX_LSB = 5;
	localparam int CW_BC_LSB = 0;
	// Block status word bits
	localparam int BSW_EOM = 15;
	localparam int BSW_BUSY = 14;
	localparam int BSW_ERR = 13;
	localparam int BSW_ROLL = 12;
	localparam int BSW_BCAST = 11;
	// Interrupt cause bits
	localparam int IRQ_EOM = 0;
	localparam int IRQ_ERR = 1;
	localparam int IRQ_SA = 2;
	localparam int IRQ_CIRC = 3;
	localparam int IRQ_MC = 4;
	localparam int IRQ_STACK = 5;
	typedef enum logic [3:0] {S_IDLE, S_SP, S_CW, S_PTR, S_DESC2, S_DESC3, S_DESC0,
		S_DATA, S_MC, S_MCCHK, S_END1, S_END2, S_UPD, S_SPWR} rsbm_state_t;
endpackage : rsbm_pkg

// ===== verilog/rsbm_top.sv
// Remote terminal subaddress buffer manager with APB configuration port
`timescale 1ns/10ps
`default_nettype none
module rsbm_top
	import rsbm_pkg::*;
(
	input wire logic I_MCLK,
	input wire logic I_RST,
	input wire logic I_CE,
	input wire logic I_PSEL,
	input wire logic I_PENABLE,
	input wire logic I_PWRITE,
	input wire logic [7:0] I_PADDR,
	input wire logic [31:0] I_PWDATA,
	output logic [31:0] O_PRDATA,
	output logic O_PREADY,
	output logic O_PSLVERR,
	input wire logic I_MSG_START,
	input wire logic [15:0] I_MSG_CMD,
	input wire logic I_MSG_BCAST,
	input wire logic I_MSG_END,
	input wire logic I_MSG_OK,
	output logic O_MSG_READY,
	input wire logic I_RX_VALID,
	input wire logic [15:0] I_RX_DATA,
	input wire logic I_TX_REQ,
	output logic O_TX_VALID,
	output logic [15:0] O_TX_DATA,
	input wire logic [15:0] I_TIME_TAG,
	output logic [15:0] O_RAM_ADDR,
	output logic [15:0] O_RAM_WDATA,
	output logic O_RAM_WE,
	output logic O_RAM_RE,
	input wire logic [15:0] I_RAM_RDATA,
	output logic O_INT_REQ,
	output logic [5:0] O_INT_CAUSE
);
	import rsbm_pkg::*;

	typedef struct packed {
		rsbm_state_t st;
		logic [15:0] cfg;
		logic [5:0] imask;
		logic [31:0] prdata;
		logic [15:0] sp;
		logic [15:0] cw;
		logic [15:0] ptr;
		logic [15:0] cmd;
		logic bc;
		logic [5:0] wc;
		logic ok;
		logic rolled;
		logic mc_hit;
		logic tx_pend;
		logic tx_valid;
		logic [15:0] tx_data;
		logic int_req;
		logic [5:0] int_cause;
		logic [5:0] last_cause;
	} rsbm_regs_t;

	rsbm_regs_t r;
	rsbm_regs_t next_r;

	// Mask of an aligned circular buffer of length 128 << (code - 1)
	function automatic logic [15:0] circ_mask(input logic [2:0] code);
		circ_mask = (CIRC_MIN_LEN << (code - 3'd1)) - 16'd1;
	endfunction : circ_mask

	// Stack sizes 256, 512, 1024, 2048 words
	function automatic logic [15:0] stack_mask(input logic [1:0] code);
		stack_mask = (16'h0100 << code) - 16'd1;
	endfunction : stack_mask

	// Advance inside an aligned window; upper bits stay, lower bits wrap
	function automatic logic [15:0] wrap_add(input logic [15:0] base, input logic [15:0] off,
		input logic [15:0] mask);
		wrap_add = (base & ~mask) | ((base + off) & mask);
	endfunction : wrap_add

	// Decoded per-message setup, derived from the latched command, control word and configuration register
	logic is_tx;
	logic is_mc;
	logic use_bc_sec;
	logic [4:0] sa;
	logic [4:0] field;
	logic [2:0] len_code;
	logic circ;
	logic dbl;
	logic [15:0] lut_base;
	logic [15:0] sp_addr;
	logic [15:0] cmask;
	logic [15:0] data_addr;
	logic [15:0] upd_ptr;
	logic [15:0] next_sp;
	logic stack_roll;
	logic upd_en;
	logic [5:0] events;

	// Lookup index from T/R, subaddress and optionally broadcast
	always_comb
	begin
		is_tx = r.cmd[10];
		sa = r.cmd[9:5];
		is_mc = (sa == 5'd0) || (sa == 5'd31);
		use_bc_sec = r.bc && r.cfg[CFG_BC_SEP] && !is_tx;
		lut_base = r.cfg[CFG_AREA_B] ? LUT_BASE_B : LUT_BASE_A;
		sp_addr = r.cfg[CFG_AREA_B] ? STACK_PTR_B : STACK_PTR_A;
		if (is_tx)
			field = r.cw[CW_TX_LSB +: 5];
		else if (use_bc_sec)
			field = r.cw[CW_BC_LSB +: 5];
		else
			field = r.cw[CW_RX_LSB +: 5];
		// Legacy mode ignores the control word buffering scheme; field bit 4 still raises the SA interrupt
		len_code = r.cfg[CFG_LEGACY] ? 3'd0 : field[2:0];
		circ = (len_code != 3'd0);
		dbl = !circ && !is_tx && !r.cfg[CFG_LEGACY] && r.cw[CW_DBL];
		cmask = circ_mask(len_code);
	end

	// Data word address and end-of-message pointer values
	always_comb
	begin
		if (circ)
			data_addr = wrap_add(r.ptr, {10'd0, r.wc}, cmask);
		else
			data_addr = r.ptr + {10'd0, r.wc};
		if (circ)
			upd_ptr = wrap_add(r.ptr, {10'd0, r.wc}, cmask);
		else
			upd_ptr = r.ptr ^ DBL_TOGGLE;
		next_sp = wrap_add(r.sp, 16'd4, stack_mask(r.cfg[1:0]));
		stack_roll = ((r.sp & stack_mask(r.cfg[1:0])) + 16'd4) > stack_mask(r.cfg[1:0]);
		// Invalid receives may keep the pointer so a retry overwrites bad data
		if (circ)
			upd_en = r.ok || (r.cfg[CFG_UPD_INV] && !(r.cfg[CFG_HOLD_RX_INV] && !is_tx));
		else
			upd_en = dbl && r.ok;
		events = '0;
		events[IRQ_EOM] = 1'b1;
		events[IRQ_ERR] = !r.ok;
		events[IRQ_SA] = field[4];
		events[IRQ_CIRC] = field[3] && circ && r.rolled;
		events[IRQ_MC] = r.mc_hit;
		events[IRQ_STACK] = stack_roll;
	end

	// Shared RAM port driven from the sequencer state
	always_comb
	begin
		O_RAM_ADDR = 16'h0000;
		O_RAM_WDATA = 16'h0000;
		O_RAM_WE = 1'b0;
		O_RAM_RE = 1'b0;
		unique case (r.st)
			S_IDLE:
			begin
			end
			S_SP:
			begin
				O_RAM_ADDR = sp_addr;
				O_RAM_RE = 1'b1;
			end
			S_CW:
			begin
				O_RAM_ADDR = lut_base + {9'd0, SEC_CW} + {11'd0, sa};
				O_RAM_RE = 1'b1;
			end
			S_PTR:
			begin
				O_RAM_ADDR = lut_base + {11'd0, sa};
				if (!is_tx)
					O_RAM_ADDR = lut_base + {9'd0, use_bc_sec ? SEC_BC : SEC_RX} + {11'd0, sa};
				O_RAM_RE = 1'b1;
			end
			S_DESC2:
			begin
				O_RAM_ADDR = {r.sp[15:2], 2'b10};
				O_RAM_WDATA = I_RAM_RDATA;
				O_RAM_WE = 1'b1;
			end
			S_DESC3:
			begin
				O_RAM_ADDR = {r.sp[15:2], 2'b11};
				O_RAM_WDATA = r.cmd;
				O_RAM_WE = 1'b1;
			end
			S_DESC0:
			begin
				O_RAM_ADDR = {r.sp[15:2], 2'b00};
				O_RAM_WDATA[BSW_BUSY] = 1'b1;
				O_RAM_WDATA[BSW_BCAST] = r.bc;
				O_RAM_WE = 1'b1;
			end
			S_DATA:
			begin
				O_RAM_ADDR = data_addr;
				O_RAM_WDATA = I_RX_DATA;
				O_RAM_WE = I_RX_VALID && !is_tx && (circ || r.wc < BLOCK_MAX);
				O_RAM_RE = I_TX_REQ && is_tx && !r.tx_pend;
			end
			S_MC:
			begin
				O_RAM_ADDR = MC_IRQ_TABLE + {13'd0, r.bc, is_tx, r.cmd[4]};
				O_RAM_RE = 1'b1;
			end
			S_MCCHK:
			begin
			end
			S_END1:
			begin
				O_RAM_ADDR = {r.sp[15:2], 2'b00};
				O_RAM_WDATA[BSW_EOM] = 1'b1;
				O_RAM_WDATA[BSW_ERR] = !r.ok;
				O_RAM_WDATA[BSW_ROLL] = r.rolled;
				O_RAM_WDATA[BSW_BCAST] = r.bc;
				O_RAM_WE = 1'b1;
			end
			S_END2:
			begin
				O_RAM_ADDR = {r.sp[15:2], 2'b01};
				O_RAM_WDATA = I_TIME_TAG;
				O_RAM_WE = 1'b1;
			end
			S_UPD:
			begin
				O_RAM_ADDR = lut_base + {11'd0, sa};
				if (!is_tx)
					O_RAM_ADDR = lut_base + {9'd0, use_bc_sec ? SEC_BC : SEC_RX} + {11'd0, sa};
				O_RAM_WDATA = upd_ptr;
				O_RAM_WE = upd_en;
			end
			S_SPWR:
			begin
				O_RAM_ADDR = sp_addr;
				O_RAM_WDATA = next_sp;
				O_RAM_WE = 1'b1;
			end
		endcase
	end

	// Next-state logic for the whole register set
	always_comb
	begin
		next_r = r;
		next_r.int_req = 1'b0;
		next_r.tx_valid = 1'b0;
		// APB: read data captured in setup so it is stable during access
		if (I_PSEL && !I_PENABLE)
		begin
			unique case (I_PADDR)
				REG_CFG1:
					next_r.prdata = {16'h0000, r.cfg};
				REG_IMASK:
					next_r.prdata = {26'd0, r.imask};
				REG_STATUS:
					next_r.prdata = {16'h0000, 7'd0, (r.st != S_IDLE), 2'd0, r.last_cause};
				default:
					next_r.prdata = 32'h0000_0000;
			endcase
		end
		if (I_PSEL && I_PENABLE && I_PWRITE)
		begin
			if (I_PADDR == REG_CFG1)
				next_r.cfg = I_PWDATA[15:0];
			if (I_PADDR == REG_IMASK)
				next_r.imask = I_PWDATA[5:0];
		end
		// Message sequencer
		unique case (r.st)
			S_IDLE:
				if (I_MSG_START)
				begin
					next_r.cmd = I_MSG_CMD;
					next_r.bc = I_MSG_BCAST;
					next_r.wc = 6'd0;
					next_r.rolled = 1'b0;
					next_r.mc_hit = 1'b0;
					next_r.tx_pend = 1'b0;
					next_r.st = S_SP;
				end
			S_SP:
				next_r.st = S_CW;
			S_CW:
			begin
				next_r.sp = I_RAM_RDATA;
				next_r.st = S_PTR;
			end
			S_PTR:
			begin
				next_r.cw = I_RAM_RDATA;
				next_r.st = S_DESC2;
			end
			S_DESC2:
			begin
				next_r.ptr = I_RAM_RDATA;
				next_r.st = S_DESC3;
			end
			S_DESC3:
				next_r.st = S_DESC0;
			S_DESC0:
				next_r.st = S_DATA;
			S_DATA:
			begin
				// Transmit words return one cycle after the RAM read
				if (r.tx_pend)
				begin
					next_r.tx_data = I_RAM_RDATA;
					next_r.tx_valid = 1'b1;
					next_r.tx_pend = 1'b0;
				end
				if (O_RAM_RE || (I_RX_VALID && !is_tx))
				begin
					next_r.tx_pend = O_RAM_RE;
					next_r.wc = r.wc + 6'd1;
				end
				if (I_MSG_END)
				begin
					next_r.ok = I_MSG_OK;
					next_r.rolled = circ && ({10'd0, r.wc} + (r.ptr & cmask)) > cmask;
					next_r.st = (is_mc && r.cfg[CFG_MC_IRQ_EN]) ? S_MC : S_END1;
				end
			end
			S_MC:
				next_r.st = S_MCCHK;
			S_MCCHK:
			begin
				next_r.mc_hit = I_RAM_RDATA[r.cmd[3:0]];
				next_r.st = S_END1;
			end
			S_END1:
				next_r.st = S_END2;
			S_END2:
				next_r.st = S_UPD;
			S_UPD:
				next_r.st = S_SPWR;
			S_SPWR:
			begin
				next_r.int_cause = events & r.imask;
				next_r.int_req = |(events & r.imask);
				next_r.last_cause = events;
				next_r.st = S_IDLE;
			end
		endcase
	end

	// State register; clock enable low freezes everything
	always_ff @(posedge I_MCLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			r <= '0;
			r.st <= S_IDLE;
			r.cfg <= CFG1_RESET;
			r.imask <= IMASK_RESET;
		end
		else if (I_CE)
		begin
			r <= next_r;
		end
	end

	// APB answers in the first access cycle unless the clock enable stalls it
	assign O_PREADY = I_CE;
	assign O_PSLVERR = I_PSEL && I_PENABLE &&
		!(I_PADDR == REG_CFG1 || I_PADDR == REG_IMASK || (I_PADDR == REG_STATUS && !I_PWRITE));
	assign O_PRDATA = r.prdata;
	assign O_MSG_READY = (r.st == S_DATA);
	assign O_TX_VALID = r.tx_valid;
	assign O_TX_DATA = r.tx_data;
	assign O_INT_REQ = r.int_req;
	assign O_INT_CAUSE = r.int_cause;
endmodule : rsbm_top
`default_nettype wire
